// ### rtl/register_data_mapper.sv
`timescale 1ns/10ps
// Function
// - Multi-byte values travel most significant byte first
// - Bitfields are 8, 16, 32 or 64 bits
// - Never report two exclusive bitfield bits together
// - Enumerations are signed, at most eight bytes
// - Binary point integers carry scale, sign, size
// - String characters only space through tilde, checked on unpack only
// - Only 16-bit registers, wide items span several
// - Non-string byte item in low byte, high zero
// - Odd octets above one, 48-bit and oversize non-string items refused
// - Wide values split, upper word at lowest register
// - Bitfields map like numbers, bit zero is LSB
// - String byte n in register n/2, even high
// - Unused trailing string bytes read as padding
module register_data_mapper (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire mapper_pkg::pack_req_t pack_req,
   output mapper_pkg::pack_rsp_t pack_rsp,
   input wire mapper_pkg::unpack_req_t unpack_req,
   output mapper_pkg::unpack_rsp_t unpack_rsp
);
   import mapper_pkg::*;

   function automatic logic [3:0] num_regs(input item_desc_t d);
      logic [5:0] half;
      half = ({1'b0, d.size_bytes} + 6'h01) >> 1;
      if (d.kind == KIND_STRING) begin
         num_regs = half[3:0];
      end else if (d.size_bytes == 5'h01) begin
         num_regs = 4'h1;
      end else begin
         num_regs = d.size_bytes[4:1];
      end
   endfunction : num_regs

   function automatic logic size_ok(input item_desc_t d);
      if (d.kind == KIND_STRING) begin
         size_ok = (d.size_bytes != 5'h00) && (d.size_bytes <= 5'h10);
      end else begin
         // Odd octet counts above one, 48 bits and beyond 64 bits are refused
         size_ok = (d.size_bytes == 5'h01) || (d.size_bytes == 5'h02) ||
                   (d.size_bytes == 5'h04) || (d.size_bytes == 5'h08);
      end
   endfunction : size_ok

   pack_rsp_t pack_rsp_d;
   pack_rsp_t pack_rsp_q;
   unpack_rsp_t unpack_rsp_d;
   unpack_rsp_t unpack_rsp_q;
   logic pk_err;
   logic [STR_BYTES-1:0] char_ok;
   logic [STR_BYTES-1:0][7:0] in_chars;

   // Pack path: item value to one register image
   always_comb begin
      logic [3:0] nregs;
      logic [3:0] sel;
      logic [3:0][15:0] nwords;
      logic [15:0][7:0] chars;
      logic [63:0] excl;
      logic [4:0] hi_n;
      logic [4:0] lo_n;
      nregs = num_regs(pack_req.desc);
      nwords = pack_req.value[63:0];
      chars = pack_req.value;
      excl = pack_req.value[63:0] & pack_req.excl_mask;
      sel = nregs - 4'h1 - {1'b0, pack_req.index};
      hi_n = {1'b0, pack_req.index, 1'b0};
      lo_n = {1'b0, pack_req.index, 1'b1};
      pk_err = 1'b0;
      pack_rsp_d.valid = pack_req.valid;
      pack_rsp_d.err = 1'b0;
      pack_rsp_d.word = WORD_RESET;
      if (!size_ok(pack_req.desc) || ({1'b0, pack_req.index} >= nregs)) begin
         pk_err = 1'b1;
      end else if (pack_req.desc.kind == KIND_BITFIELD && !$onehot0(excl)) begin
         // Better an error than a status that claims two exclusive states
         pk_err = 1'b1;
      end
      if (pack_req.valid && !pk_err) begin
         if (pack_req.desc.kind == KIND_STRING) begin
            // First character lands in the high byte of the first register
            pack_rsp_d.word[15:8] = (hi_n < pack_req.desc.size_bytes) ?
                                    chars[hi_n[3:0]] : PAD_CHAR;
            pack_rsp_d.word[7:0] = (lo_n < pack_req.desc.size_bytes) ?
                                   chars[lo_n[3:0]] : PAD_CHAR;
         end else if (pack_req.desc.size_bytes == 5'h01) begin
            pack_rsp_d.word = {HIGH_BYTE_ZERO, pack_req.value[7:0]};
         end else begin
            // Upper word goes out at the lowest index, bit 0 stays LSB
            pack_rsp_d.word = nwords[sel[1:0]];
         end
      end
      pack_rsp_d.err = pack_req.valid && pk_err;
   end

   genvar g;
   generate
      for (g = 0; g < STR_BYTES; g++) begin : g_chars
         assign in_chars[g] = (g % 2 == 0) ? unpack_req.words[g/2][15:8]
                                           : unpack_req.words[g/2][7:0];
         ascii_char_check u_ascii_char_check (
            .char_in(in_chars[g]),
            .printable(char_ok[g])
         );
      end
   endgenerate

   // Unpack path: whole register block back to an item value
   always_comb begin
      logic [3:0] nregs;
      logic [63:0] acc;
      logic [63:0] ext;
      logic sext;
      logic bad;
      nregs = num_regs(unpack_req.desc);
      acc = 64'h0;
      ext = 64'h0;
      bad = !size_ok(unpack_req.desc) || (unpack_req.count != nregs);
      // Enumerations are always signed whatever the flag says
      sext = unpack_req.desc.is_signed || (unpack_req.desc.kind == KIND_ENUM);
      unpack_rsp_d.valid = unpack_req.valid;
      unpack_rsp_d.value = VALUE_RESET;
      for (int i = 0; i < MAX_REGS; i++) begin
         if (i < nregs) begin
            acc = {acc[47:0], unpack_req.words[i]};
         end
      end
      unique case (unpack_req.desc.size_bytes)
         5'h01: begin
            // A one-character string keeps its character in the high byte
            bad = bad || (unpack_req.desc.kind != KIND_STRING &&
                          unpack_req.words[0][15:8] != HIGH_BYTE_ZERO);
            ext = sext ? {{56{unpack_req.words[0][7]}}, unpack_req.words[0][7:0]}
                       : {56'h0, unpack_req.words[0][7:0]};
         end
         5'h02: ext = sext ? {{48{acc[15]}}, acc[15:0]} : {48'h0, acc[15:0]};
         5'h04: ext = sext ? {{32{acc[31]}}, acc[31:0]} : {32'h0, acc[31:0]};
         default: ext = acc;
      endcase
      if (unpack_req.desc.kind == KIND_STRING) begin
         for (int n = 0; n < STR_BYTES; n++) begin
            if (n < unpack_req.desc.size_bytes) begin
               unpack_rsp_d.value[8*n +: 8] = in_chars[n];
               bad = bad || !char_ok[n];
            end else begin
               unpack_rsp_d.value[8*n +: 8] = PAD_CHAR;
            end
         end
      end else begin
         unpack_rsp_d.value = {64'h0, ext};
      end
      if (!unpack_req.valid || bad) begin
         unpack_rsp_d.value = VALUE_RESET;
      end
      unpack_rsp_d.err = unpack_req.valid && bad;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pack_rsp_q <= '0;
         unpack_rsp_q <= '0;
      end else if (clk_en) begin
         pack_rsp_q <= pack_rsp_d;
         unpack_rsp_q <= unpack_rsp_d;
      end
   end

   assign pack_rsp = pack_rsp_q;
   assign unpack_rsp = unpack_rsp_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   single_cycle_a: assert property (
      clk_en && pack_req.valid |=> pack_rsp_q.valid && unpack_rsp_q.valid == $past(unpack_req.valid))
      else $error("answer missing one cycle after request");

   byte_high_zero_a: assert property (
      clk_en && pack_req.valid && !pk_err && pack_req.desc.kind != KIND_STRING &&
      pack_req.desc.size_bytes == 5'h01 |=> pack_rsp_q.word[15:8] == 8'h00)
      else $error("byte item high byte not zero");

   upper_word_a: assert property (
      clk_en && pack_req.valid && !pk_err &&
      pack_req.desc.kind == KIND_BINARY_POINT_INTEGER &&
      pack_req.desc.size_bytes == 5'h04 && pack_req.index == 3'h0
      |=> pack_rsp_q.word == $past(pack_req.value[31:16]))
      else $error("upper word not at lowest register");

   bad_size_a: assert property (
      clk_en && pack_req.valid && pack_req.desc.kind != KIND_STRING &&
      (pack_req.desc.size_bytes == 5'h03 || pack_req.desc.size_bytes == 5'h06)
      |=> pack_rsp_q.err && pack_rsp_q.word == 16'h0000)
      else $error("illegal item size not refused");

   exclusive_bits_a: assert property (
      pack_rsp_q.valid && !pack_rsp_q.err |->
      $onehot0(pack_rsp_q.word & $past(pack_req.excl_mask[15:0])) ||
      $past(pack_req.desc.kind) != KIND_BITFIELD || !$past(clk_en) ||
      $past(pack_req.desc.size_bytes) > 5'h02)
      else $error("two exclusive bits reported");

   string_order_a: assert property (
      clk_en && pack_req.valid && !pk_err && pack_req.desc.kind == KIND_STRING &&
      pack_req.index == 3'h1 && pack_req.desc.size_bytes >= 5'h04
      |=> pack_rsp_q.word == {$past(pack_req.value[23:16]), $past(pack_req.value[31:24])})
      else $error("string bytes misplaced");

   string_pad_a: assert property (
      clk_en && pack_req.valid && pack_req.desc.kind == KIND_STRING &&
      pack_req.desc.size_bytes == 5'h01 && pack_req.index == 3'h0
      |=> pack_rsp_q.word[7:0] == 8'h20)
      else $error("trailing string byte not padded");

   bit_zero_a: assert property (
      clk_en && pack_req.valid && !pk_err && pack_req.desc.kind == KIND_BITFIELD &&
      pack_req.desc.size_bytes == 5'h02 |=> pack_rsp_q.word[0] == $past(pack_req.value[0]))
      else $error("bit zero not in register LSB");

   bad_char_a: assert property (
      clk_en && unpack_req.valid && unpack_req.desc.kind == KIND_STRING &&
      unpack_req.words[0][15:8] < 8'h20 |=> unpack_rsp_q.err)
      else $error("unprintable character accepted");

   enum_sign_a: assert property (
      clk_en && unpack_req.valid && unpack_req.desc.kind == KIND_ENUM &&
      unpack_req.desc.size_bytes == 5'h02 && unpack_req.count == 4'h1
      |=> unpack_rsp_q.value[63:16] == {48{unpack_rsp_q.value[15]}})
      else $error("enumeration not sign extended");

endmodule : register_data_mapper

// ### inc/mapper_pkg.sv
package mapper_pkg;

   localparam int unsigned STR_BYTES = 16;
   localparam int unsigned MAX_REGS = 8;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [127:0] VALUE_RESET = 128'h0;
   localparam logic [7:0] ASCII_LO = 8'h20;
   localparam logic [7:0] ASCII_HI = 8'h7e;
   localparam logic [7:0] PAD_CHAR = 8'h20;
   localparam logic [7:0] HIGH_BYTE_ZERO = 8'h00;

   typedef enum logic [1:0] {
      KIND_BITFIELD = 2'h0,
      KIND_ENUM = 2'h1,
      KIND_BINARY_POINT_INTEGER = 2'h2,
      KIND_STRING = 2'h3
   } item_kind_t;

   typedef struct packed {
      item_kind_t kind;
      logic is_signed;
      logic [7:0] scale_exp;
      logic [4:0] size_bytes;
   } item_desc_t;

   typedef struct packed {
      logic valid;
      item_desc_t desc;
      logic [2:0] index;
      logic [127:0] value;
      logic [63:0] excl_mask;
   } pack_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [15:0] word;
   } pack_rsp_t;

   typedef struct packed {
      logic valid;
      item_desc_t desc;
      logic [3:0] count;
      logic [7:0][15:0] words;
   } unpack_req_t;

   typedef struct packed {
      logic valid;
      logic err;
      logic [127:0] value;
   } unpack_rsp_t;

endpackage : mapper_pkg

// ### rtl/ascii_char_check.sv
`timescale 1ns/10ps
module ascii_char_check (
   input wire logic [7:0] char_in,
   output logic printable
);
   import mapper_pkg::*;

   assign printable = (char_in >= ASCII_LO) && (char_in <= ASCII_HI);

endmodule : ascii_char_check

// ### test/master_model.sv
`timescale 1ns/10ps
module master_model (
   input wire logic core_clk,
   output mapper_pkg::unpack_req_t unpack_req
);
   import mapper_pkg::*;
   initial begin
      unpack_req = '0;
   end
   // Scale, round half up, complement if negative
   function automatic logic [63:0] to_binary_point(input real v, input int bpl);
      logic [63:0] m;
      m = 64'(longint'($floor(((v < 0.0) ? -v : v) * (2.0 ** bpl) + 0.5)));
      return (v < 0.0) ? -m : m;
   endfunction : to_binary_point
   // Negative when signed with top bit set: complement, scale, negate
   function automatic real from_binary_point(input logic [63:0] v, input int bpl,
         input logic sgn);
      if (sgn && v[63]) begin
         return -(real'(-v) / (2.0 ** bpl));
      end
      return real'(v) / (2.0 ** bpl);
   endfunction : from_binary_point
   // What a user sees: no leading nulls, no trailing spaces
   function automatic string present(input logic [127:0] v);
      string s;
      int first;
      int last;
      s = "";
      first = 0;
      last = int'(STR_BYTES) - 1;
      while (first < int'(STR_BYTES) && v[8*first +: 8] == 8'h00) begin
         first++;
      end
      while (last >= first && v[8*last +: 8] == 8'h20) begin
         last--;
      end
      for (int i = first; i <= last; i++) begin
         s = $sformatf("%s%c", s, v[8*i +: 8]);
      end
      return s;
   endfunction : present
   task automatic send(input item_desc_t d, input logic [3:0] n, input logic [127:0] w);
      @(negedge core_clk);
      unpack_req <= '{1'b1, d, n, w};
      @(negedge core_clk);
      unpack_req.valid <= 1'b0;
      unpack_req.words <= ~w; // Stale words must not pass as fresh
   endtask : send
   // Whole item, space padded, first char in high byte
   task automatic send_str(input string s, input int len);
      logic [7:0][15:0] w;
      w = {8{16'h2020}};
      for (int i = 0; i < s.len(); i++) begin
         w[i / 2][((i % 2) ? 7 : 15) -: 8] = s[i];
      end
      send('{KIND_STRING, 1'b0, 8'h00, 5'(len)}, 4'((len + 1) / 2), w);
   endtask : send_str
endmodule : master_model

// ### test/register_data_mapper_tb_top.sv
`timescale 1ns/10ps
module register_data_mapper_tb_top;
   import mapper_pkg::*;
   logic core_clk;
   logic reset;
   logic clk_en;
   pack_req_t pack_req;
   pack_rsp_t pack_rsp;
   unpack_req_t unpack_req;
   unpack_rsp_t unpack_rsp;
   int n_fail;
   int num_checks;
   localparam item_kind_t KIND_NUM = KIND_BINARY_POINT_INTEGER;
   register_data_mapper u_register_data_mapper (.core_clk(core_clk), .reset(reset),
      .clk_en(clk_en), .pack_req(pack_req), .pack_rsp(pack_rsp), .unpack_req(unpack_req),
      .unpack_rsp(unpack_rsp));
   master_model u_master_model (.core_clk(core_clk), .unpack_req(unpack_req));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic test_done;
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   task automatic cmp_pack(input pack_rsp_t exp);
      num_checks++;
      if (pack_rsp !== exp) begin
         n_fail++;
         $display("Error %0t pack got %h want %h", $time, pack_rsp, exp);
      end
   endtask : cmp_pack
   task automatic cmp_unpack(input unpack_rsp_t exp);
      num_checks++;
      if (unpack_rsp !== exp) begin
         n_fail++;
         $display("Error %0t unpack got %h want %h", $time, unpack_rsp, exp);
      end
   endtask : cmp_unpack
   task automatic cmp_real(input real got, input real exp, input real tol);
      num_checks++;
      if (got > exp + tol || got < exp - tol) begin
         n_fail++;
         $display("Error %0t real got %f want %f", $time, got, exp);
      end
   endtask : cmp_real
   task automatic cmp_str(input string got, input string exp);
      num_checks++;
      if (got != exp) begin
         n_fail++;
         $display("Error %0t text got %s want %s", $time, got, exp);
      end
   endtask : cmp_str
   // Answer is due one rising edge after the request
   task automatic pk(input item_kind_t k, input logic [4:0] sz, input logic [2:0] idx,
         input logic [127:0] v, input logic [63:0] m, input logic e, input logic [15:0] w);
      @(negedge core_clk);
      pack_req <= '{1'b1, '{k, 1'b0, 8'h00, sz}, idx, v, m};
      @(negedge core_clk);
      pack_req.valid <= 1'b0;
      pack_req.value <= ~v;
      cmp_pack('{1'b1, e, w});
   endtask : pk
   // Mid-run reset must clear a standing answer at once
   task automatic t_reset;
      cmp_pack('0);
      cmp_unpack('0);
      pack_req <= '{1'b1, '{KIND_NUM, 1'b0, 8'h00, 5'h02}, 3'h0, 128'h1234, 64'h0};
      @(negedge core_clk);
      cmp_pack('{1'b1, 1'b0, 16'h1234});
      reset = 1'b1;
      pack_req <= '0;
      #1;
      cmp_pack('0);
      cmp_unpack('0);
      @(negedge core_clk);
      reset = 1'b0;
   endtask : t_reset
   // Low enable must freeze the answer
   task automatic t_hold;
      @(negedge core_clk);
      pack_req <= '{1'b1, '{KIND_NUM, 1'b0, 8'h00, 5'h02}, 3'h0, 128'habcd, 64'h0};
      @(negedge core_clk);
      clk_en <= 1'b0;
      pack_req <= '0;
      repeat (2) @(negedge core_clk);
      cmp_pack('{1'b1, 1'b0, 16'habcd});
      clk_en <= 1'b1;
      @(negedge core_clk);
      cmp_pack('0);
   endtask : t_hold
   task automatic t_words;
      pk(KIND_NUM, 5'h04, 3'h0, 128'h12345678, 64'h0, 1'b0, 16'h1234);
      pk(KIND_NUM, 5'h04, 3'h1, 128'h12345678, 64'h0, 1'b0, 16'h5678);
      pk(KIND_ENUM, 5'h08, 3'h3, 128'h1122334455667788, 64'h0, 1'b0, 16'h7788);
      pk(KIND_BITFIELD, 5'h08, 3'h0, 128'h8001000000000001, 64'h0, 1'b0, 16'h8001);
      pk(KIND_NUM, 5'h01, 3'h0, 128'ha5, 64'h0, 1'b0, 16'h00a5);
      pk(KIND_NUM, 5'h02, 3'h1, 128'h1234, 64'h0, 1'b1, 16'h0000);
   endtask : t_words
   task automatic t_sizes;
      logic [4:0] bad[6] = '{5'h00, 5'h03, 5'h05, 5'h06, 5'h09, 5'h10};
      foreach (bad[i]) begin
         pk(KIND_NUM, bad[i], 3'h0, 128'h1, 64'h0, 1'b1, 16'h0000);
         pk(KIND_BITFIELD, bad[i], 3'h0, 128'h1, 64'h0, 1'b1, 16'h0000);
      end
   endtask : t_sizes
   task automatic t_excl;
      pk(KIND_BITFIELD, 5'h02, 3'h0, 128'h0003, 64'h3, 1'b1, 16'h0000);
      pk(KIND_BITFIELD, 5'h02, 3'h0, 128'h0102, 64'h3, 1'b0, 16'h0102);
   endtask : t_excl
   task automatic t_str_pack;
      pk(KIND_STRING, 5'h03, 3'h0, 128'h55794d, 64'h0, 1'b0, 16'h4d79);
      pk(KIND_STRING, 5'h03, 3'h1, 128'h55794d, 64'h0, 1'b0, 16'h5520);
      pk(KIND_STRING, 5'h03, 3'h2, 128'h55794d, 64'h0, 1'b1, 16'h0000);
      pk(KIND_STRING, 5'h04, 3'h1, 128'h44434241, 64'h0, 1'b0, 16'h4344);
      pk(KIND_STRING, 5'h01, 3'h0, 128'h41, 64'h0, 1'b0, 16'h4120);
   endtask : t_str_pack
   task automatic t_num_unpack;
      logic [63:0] enc;
      real dec;
      enc = u_master_model.to_binary_point(-56.8, 5);
      u_master_model.send('{KIND_ENUM, 1'b0, 8'h00, 5'h02}, 4'h1, 128'hfff0);
      cmp_unpack('{1'b1, 1'b0, 128'hffff_ffff_ffff_fff0});
      u_master_model.send('{KIND_NUM, 1'b1, 8'h05, 5'h02}, 4'h1, {112'h0, enc[15:0]});
      cmp_unpack('{1'b1, 1'b0, 128'hffff_ffff_ffff_f8e6});
      dec = u_master_model.from_binary_point(unpack_rsp.value[63:0], 5, 1'b1);
      cmp_real(dec, -56.8, 0.03125);
      u_master_model.send('{KIND_NUM, 1'b0, 8'h00, 5'h04}, 4'h2, 128'h0002_8001);
      cmp_unpack('{1'b1, 1'b0, 128'h8001_0002});
      u_master_model.send('{KIND_NUM, 1'b0, 8'h00, 5'h01}, 4'h1, 128'h00f0);
      cmp_unpack('{1'b1, 1'b0, 128'hf0});
      u_master_model.send('{KIND_NUM, 1'b0, 8'h00, 5'h01}, 4'h1, 128'h01f0);
      cmp_unpack('{1'b1, 1'b1, 128'h0});
      u_master_model.send('{KIND_NUM, 1'b0, 8'h00, 5'h06}, 4'h3, 128'h1);
      cmp_unpack('{1'b1, 1'b1, 128'h0});
   endtask : t_num_unpack
   task automatic t_str_unpack;
      logic [127:0] exp;
      exp = {16{8'h20}};
      exp[47:0] = 48'h53_50_55_20_79_4d;
      u_master_model.send_str("My UPS", 6);
      cmp_unpack('{1'b1, 1'b0, exp});
      cmp_str(u_master_model.present(unpack_rsp.value), "My UPS");
      exp = {{15{8'h20}}, 8'h5a};
      u_master_model.send_str("Z", 1);
      cmp_unpack('{1'b1, 1'b0, exp});
      u_master_model.send_str("A\x7f", 2);
      cmp_unpack('{1'b1, 1'b1, 128'h0});
      u_master_model.send('{KIND_STRING, 1'b0, 8'h00, 5'h02}, 4'h1, 128'h1f41);
      cmp_unpack('{1'b1, 1'b1, 128'h0});
      u_master_model.send('{KIND_STRING, 1'b0, 8'h00, 5'h06}, 4'h2, 128'h4142_4344);
      cmp_unpack('{1'b1, 1'b1, 128'h0});
   endtask : t_str_unpack
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      pack_req = '0;
      n_fail = 0;
      num_checks = 0;
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      @(negedge core_clk);
      t_reset;
      t_hold;
      t_words;
      t_sizes;
      t_excl;
      t_str_pack;
      t_num_unpack;
      t_str_unpack;
      test_done;
   end
   // Whole run is well under two thousand cycles
   initial begin
      #20000;
      n_fail++;
      test_done;
   end
endmodule : register_data_mapper_tb_top
